/* File: hw/isr_event_if.sv */
/*
  Carrier between the top module and one sticky event register with its
  enable mask.
  Assumes the owner and the user run on the same clock.
*/
`default_nettype none

interface isr_event_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] set;
  logic clear;
  logic en_wr;
  logic [WIDTH-1:0] en_data;
  logic [WIDTH-1:0] events;
  logic [WIDTH-1:0] enable;
  logic summary;

  modport owner(input set, input clear, input en_wr, input en_data,
                output events, output enable, output summary);
  modport user(output set, output clear, output en_wr, output en_data,
               input events, input enable, input summary);
endinterface : isr_event_if

`default_nettype wire

/* File: hw/isr_event_reg.sv */
/*
  Sticky event register with enable mask and enabled-event summary.
  Assumes set pulses and clear strobes synchronous to clk.
*/
`default_nettype none

module isr_event_reg
  import isr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0,
  parameter logic [WIDTH-1:0] VALID_MASK = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  isr_event_if.owner ev
);
  typedef struct packed {
    logic [WIDTH-1:0] events;
    logic [WIDTH-1:0] enable;
  } isr_evreg_t;

  isr_evreg_t st_r;
  isr_evreg_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (ev.clear) begin
      st_nxt.events = '0;
    end
    // A set in the clearing cycle is kept so the event is never lost.
    st_nxt.events = st_nxt.events | (ev.set & VALID_MASK);
    if (ev.en_wr) begin
      st_nxt.enable = ev.en_data & VALID_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{events: RESET_VAL, enable: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ev.events = st_r.events;
  assign ev.enable = st_r.enable;
  assign ev.summary = |(st_r.events & st_r.enable);

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    ev.clear |=> ((st_r.events & VALID_MASK) & $past(ev.set)) == ($past(ev.set) & VALID_MASK))
    else $error("event set lost during clear");
  unused_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.events & ~VALID_MASK) == '0 && (st_r.enable & ~VALID_MASK) == '0)
    else $error("unused event bit set");
endmodule : isr_event_reg

`default_nettype wire

/* File: hw/isr_pkg.sv */
/*
  Shared constants and types of the status reporting block: bit positions of
  the status byte and of the standard event register, reset values, valid-bit
  masks and the command codes.
  Assumes one instrument clock; the command parser outside presents commands.
*/
`default_nettype none

package isr_pkg;

  // Status byte bit positions.
  localparam int STB_OPERATIONAL_SUMMARY_BIT_BIT = 7;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ERR_BIT = 2;
  localparam int STB_RSR_BIT = 0;

  // Standard event register bit positions.
  localparam int ESR_PON_BIT = 7;
  localparam int ESR_URQ_BIT = 6;
  localparam int ESR_CMD_BIT = 5;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_DDE_BIT = 3;
  localparam int ESR_QYE_BIT = 2;
  localparam int ESR_RQC_BIT = 1;
  localparam int ESR_OPC_BIT = 0;

  // Reset values and masks of implemented bits.
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESR_VALID = 8'hfd;
  localparam logic [15:0] LOW_RESET = 16'h0000;
  localparam logic [15:0] LOW_VALID = 16'h7fff;
  localparam logic [7:0] SRE_REQ_MASK = 8'hbf;

  typedef enum logic [3:0] {
    ISR_CMD_STB_QUERY = 4'h0,
    ISR_CMD_SERIAL_POLL = 4'h1,
    ISR_CMD_SRE_WRITE = 4'h2,
    ISR_CMD_SRE_QUERY = 4'h3,
    ISR_CMD_ESR_QUERY = 4'h4,
    ISR_CMD_ESE_WRITE = 4'h5,
    ISR_CMD_ESE_QUERY = 4'h6,
    ISR_CMD_CLEAR = 4'h7,
    ISR_CMD_OPERATIONAL_SUMMARY_BIT_QUERY = 4'h8,
    ISR_CMD_OPERATIONAL_SUMMARY_BIT_EN_WRITE = 4'h9,
    ISR_CMD_OPERATIONAL_SUMMARY_BIT_EN_QUERY = 4'ha,
    ISR_CMD_QUES_QUERY = 4'hb,
    ISR_CMD_QUES_EN_WRITE = 4'hc,
    ISR_CMD_QUES_EN_QUERY = 4'hd
  } isr_cmd_t;

endpackage : isr_pkg

`default_nettype wire

/* File: hw/isr_request_gen.sv */
/*
  Service request generator: SRQ line and request-service flag.
  Assumes a serial poll strobe of one cycle from the bus interface.
*/
`default_nettype none

module isr_request_gen
  import isr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] stb_core,
  input wire logic [7:0] service_request_enable,
  input wire logic serial_poll,
  output wire logic srq,
  output wire logic request_service_flag,
  output wire logic master_summary_flag
);
  typedef struct packed {
    logic srq;
    logic request_service_flag;
  } isr_reqgen_t;

  isr_reqgen_t st_r;
  isr_reqgen_t st_nxt;
  logic cause;

  assign cause = |(stb_core & service_request_enable & SRE_REQ_MASK);

  always_comb begin
    st_nxt = st_r;
    st_nxt.srq = cause;
    if (serial_poll) begin
      st_nxt.request_service_flag = 1'b0;
    end
    // A new request rising in the poll cycle wins over the clear.
    if (cause && !st_r.srq) begin
      st_nxt.request_service_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign srq = st_r.srq;
  assign request_service_flag = st_r.request_service_flag;
  assign master_summary_flag = st_r.srq;

  rqs_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st_r.srq) |-> st_r.request_service_flag)
    else $error("request-service flag missing on new request");
endmodule : isr_request_gen

`default_nettype wire

/* File: hw/isr_status_reporting.sv */
/*
  Status reporting block: status byte, service request enable, standard event
  register with its enable, and the operational and questionable registers.
  Assumes a command parser that presents one decoded command per cycle and
  takes one-cycle replies, and event sources giving one-cycle pulses.
*/
// Overview of operation
// - An 8-bit status byte summarises reply queue, error queue and event register.
// - Bit 6 is request-service on serial poll, master summary on query.
// - Request enable mask gates each status bit onto SRQ, never bit 6.
// - Mask value 20 makes SRQ follow message available or error queue bits.
// - Status bit 7, operational summary, always reads zero.
// - Request-service flag marks SRQ assertion and clears on serial poll.
// - Master summary is read-only and clears only when its causes clear.
// - Status bit 5 is set when any enabled standard event bit is set.
// - Status bit 4 is set while a reply message waits.
// - Status bit 2 is set while the error queue holds a message.
// - An 8-bit standard event register is readable by its query.
// - A standard event enable mask selects which events feed bit 5.
// - Event bit 7 is set after power-up until read or cleared.
// - Event bit 6 is set on manual return to local operation.
// - Event bit 5 is set on a remote command error.
// - Event bit 4 is set on an execution error.
// - Event bit 3 is set on an internal device fault.
// - Event bit 2 is set on a message protocol error.
// - Event bit 1, bus control request, is never set.
// - Event bit 0 is set when all requested operations complete.
// - Operational and questionable 16-bit registers with enables; bit 15 reads zero.
`default_nettype none

module isr_status_reporting
  import isr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire isr_cmd_t cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic msg_available,
  input wire logic err_queue_pending,
  input wire logic ready_summary,
  input wire logic manual_local_evt,
  input wire logic command_error_evt,
  input wire logic execution_error_evt,
  input wire logic internal_fault_evt,
  input wire logic protocol_error_evt,
  input wire logic operations_done_evt,
  input wire logic [15:0] operational_summary_bit_evt,
  input wire logic [15:0] ques_evt,
  output wire logic srq,
  output wire logic rsp_valid,
  output wire logic [15:0] rsp_data
);
  typedef struct packed {
    logic [7:0] service_request_enable;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } isr_top_t;

  isr_top_t st_r;
  isr_top_t st_nxt;

  isr_event_if #(.WIDTH(8)) std_if ();
  isr_event_if #(.WIDTH(16)) operational_summary_bit_if ();
  isr_event_if #(.WIDTH(16)) ques_if ();

  logic [7:0] stb_core;
  logic [7:0] std_set;
  logic serial_poll;
  logic clear_all;
  logic request_service_flag;
  logic master_summary_flag;

  function automatic logic [15:0] widen8(input logic [7:0] v);
    return {8'h00, v};
  endfunction : widen8

  function automatic logic [7:0] with_bit6(input logic [7:0] v, input logic b);
    logic [7:0] r;
    r = v;
    r[STB_RQS_BIT] = b;
    return r;
  endfunction : with_bit6

  assign serial_poll = cmd_valid && cmd_code == ISR_CMD_SERIAL_POLL;
  assign clear_all = cmd_valid && cmd_code == ISR_CMD_CLEAR;

  // Status byte without bit 6; bit 6 is chosen by the kind of read.
  always_comb begin
    stb_core = 8'h00;
    stb_core[STB_OPERATIONAL_SUMMARY_BIT_BIT] = 1'b0;
    stb_core[STB_ESB_BIT] = std_if.summary;
    stb_core[STB_MAV_BIT] = msg_available;
    stb_core[STB_ERR_BIT] = err_queue_pending;
    stb_core[STB_RSR_BIT] = ready_summary;
  end

  // Power-on bit 7 comes only from the register's reset value.
  always_comb begin
    std_set = 8'h00;
    std_set[ESR_URQ_BIT] = manual_local_evt;
    std_set[ESR_CMD_BIT] = command_error_evt;
    std_set[ESR_EXE_BIT] = execution_error_evt;
    std_set[ESR_DDE_BIT] = internal_fault_evt;
    std_set[ESR_QYE_BIT] = protocol_error_evt;
    std_set[ESR_RQC_BIT] = 1'b0;
    std_set[ESR_OPC_BIT] = operations_done_evt;
  end

  // Reading an event register clears it; a clear-status clears all three.
  assign std_if.set = std_set;
  assign std_if.clear = clear_all || (cmd_valid && cmd_code == ISR_CMD_ESR_QUERY);
  assign std_if.en_wr = cmd_valid && cmd_code == ISR_CMD_ESE_WRITE;
  assign std_if.en_data = cmd_data[7:0];

  assign operational_summary_bit_if.set = operational_summary_bit_evt;
  assign operational_summary_bit_if.clear = clear_all || (cmd_valid && cmd_code == ISR_CMD_OPERATIONAL_SUMMARY_BIT_QUERY);
  assign operational_summary_bit_if.en_wr = cmd_valid && cmd_code == ISR_CMD_OPERATIONAL_SUMMARY_BIT_EN_WRITE;
  assign operational_summary_bit_if.en_data = cmd_data;

  assign ques_if.set = ques_evt;
  assign ques_if.clear = clear_all || (cmd_valid && cmd_code == ISR_CMD_QUES_QUERY);
  assign ques_if.en_wr = cmd_valid && cmd_code == ISR_CMD_QUES_EN_WRITE;
  assign ques_if.en_data = cmd_data;

  isr_event_reg #(
    .WIDTH(8),
    .RESET_VAL(ESR_RESET),
    .VALID_MASK(ESR_VALID)
  ) u_std_events (
    .clk(clk),
    .rst_n(rst_n),
    .ev(std_if)
  );

  // The lower layer reports nowhere: its summaries stay unused in the byte.
  isr_event_reg #(
    .WIDTH(16),
    .RESET_VAL(LOW_RESET),
    .VALID_MASK(LOW_VALID)
  ) u_operational_summary_bit_events (
    .clk(clk),
    .rst_n(rst_n),
    .ev(operational_summary_bit_if)
  );

  isr_event_reg #(
    .WIDTH(16),
    .RESET_VAL(LOW_RESET),
    .VALID_MASK(LOW_VALID)
  ) u_ques_events (
    .clk(clk),
    .rst_n(rst_n),
    .ev(ques_if)
  );

  // SRQ is only meaningful on the parallel bus; a serial host polls instead.
  isr_request_gen u_request (
    .clk(clk),
    .rst_n(rst_n),
    .stb_core(stb_core),
    .service_request_enable(st_r.service_request_enable),
    .serial_poll(serial_poll),
    .srq(srq),
    .request_service_flag(request_service_flag),
    .master_summary_flag(master_summary_flag)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.rsp_data = 16'h0000;
    if (cmd_valid) begin
      unique case (cmd_code)
        ISR_CMD_STB_QUERY: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = widen8(with_bit6(stb_core, master_summary_flag));
        end
        ISR_CMD_SERIAL_POLL: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = widen8(with_bit6(stb_core, request_service_flag));
        end
        ISR_CMD_SRE_WRITE: begin
          st_nxt.service_request_enable = cmd_data[7:0];
        end
        ISR_CMD_SRE_QUERY: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = widen8(st_r.service_request_enable);
        end
        ISR_CMD_ESR_QUERY: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = widen8(std_if.events);
        end
        ISR_CMD_ESE_QUERY: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = widen8(std_if.enable);
        end
        ISR_CMD_OPERATIONAL_SUMMARY_BIT_QUERY: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = operational_summary_bit_if.events;
        end
        ISR_CMD_OPERATIONAL_SUMMARY_BIT_EN_QUERY: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = operational_summary_bit_if.enable;
        end
        ISR_CMD_QUES_QUERY: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = ques_if.events;
        end
        ISR_CMD_QUES_EN_QUERY: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = ques_if.enable;
        end
        ISR_CMD_ESE_WRITE, ISR_CMD_CLEAR, ISR_CMD_OPERATIONAL_SUMMARY_BIT_EN_WRITE,
        ISR_CMD_QUES_EN_WRITE: begin
          st_nxt.rsp_valid = 1'b0;
        end
        default: begin
          // Codes 4'he and 4'hf are ignored without a reply.
          st_nxt.rsp_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{service_request_enable: SRE_RESET, rsp_valid: 1'b0, rsp_data: 16'h0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid = st_r.rsp_valid;
  assign rsp_data = st_r.rsp_data;

  // Helper for the power-up check: low only until the first edge after reset.
  logic seen_edge_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_edge_r <= 1'b0;
    end else begin
      seen_edge_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence stb_query_s;
    cmd_valid && cmd_code == ISR_CMD_STB_QUERY;
  endsequence
  sequence poll_s;
    cmd_valid && cmd_code == ISR_CMD_SERIAL_POLL;
  endsequence
  sequence esr_query_s;
    cmd_valid && cmd_code == ISR_CMD_ESR_QUERY;
  endsequence

  stb_query_reply_a: assert property (
    stb_query_s |=> rsp_valid && rsp_data[STB_RQS_BIT] == $past(master_summary_flag)
      && rsp_data[15:8] == 8'h00)
    else $error("status query reply wrong");
  poll_reply_a: assert property (
    poll_s |=> rsp_valid && rsp_data[STB_RQS_BIT] == $past(request_service_flag))
    else $error("serial poll reply wrong");
  operational_summary_bit_bit_zero_a: assert property (
    rsp_valid && $past(cmd_code == ISR_CMD_STB_QUERY || serial_poll)
      |-> rsp_data[STB_OPERATIONAL_SUMMARY_BIT_BIT] == 1'b0 && rsp_data[3] == 1'b0 && rsp_data[1] == 1'b0)
    else $error("unsupported status bit reads one");
  queue_bits_a: assert property (
    stb_query_s |=> rsp_data[STB_MAV_BIT] == $past(msg_available)
      && rsp_data[STB_ERR_BIT] == $past(err_queue_pending))
    else $error("queue bits wrong in status byte");
  srq_cause_a: assert property (
    srq == $past(|(stb_core & st_r.service_request_enable & SRE_REQ_MASK)))
    else $error("SRQ does not follow enabled status");
  sre_twenty_a: assert property (
    st_r.service_request_enable == 8'h14 && (msg_available || err_queue_pending) ##1 st_r.service_request_enable == 8'h14
      |-> srq)
    else $error("mask 20 failed to raise SRQ");
  poll_clears_rqs_a: assert property (
    poll_s ##1 srq && $past(srq) |-> !request_service_flag)
    else $error("serial poll did not clear request-service");
  esb_summary_a: assert property (
    |(std_if.events & std_if.enable) |-> stb_core[STB_ESB_BIT])
    else $error("event summary bit missing");
  esr_read_clear_a: assert property (
    esr_query_s |=> rsp_data[7:0] == $past(std_if.events)
      && std_if.events == ($past(std_set) & ESR_VALID))
    else $error("event register read or clear wrong");
  power_flag_a: assert property (
    !seen_edge_r |-> std_if.events[ESR_PON_BIT])
    else $error("power-cycled flag not set after reset");
  pon_hold_a: assert property (
    $fell(std_if.events[ESR_PON_BIT]) |-> $past(std_if.clear))
    else $error("power-cycled flag fell without clear");
  rqc_never_a: assert property (
    !std_if.events[ESR_RQC_BIT])
    else $error("bus control request flag set");
  low_bit15_a: assert property (
    !operational_summary_bit_if.events[15] && !ques_if.events[15] && !operational_summary_bit_if.enable[15]
      && !ques_if.enable[15])
    else $error("lower layer bit 15 set");
endmodule : isr_status_reporting

`default_nettype wire

/* File: tb/isr_host_model.sv */
/*
  Host model: issues decoded commands to the status block as a bus or
  serial-port host would, and catches each one-cycle reply.
  Assumes the block's clock; commands change only at its falling edge.
*/
`default_nettype none

module isr_host_model
  import isr_pkg::*;
(
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output var logic cmd_valid,
  output var isr_cmd_t cmd_code,
  output var logic [15:0] cmd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_valid = 1'b0;
    cmd_code = ISR_CMD_STB_QUERY;
    cmd_data = 16'h0000;
  end

  // A serial-port host sees no service request, so it learns of events only
  // by querying through this task.
  task automatic issue(input isr_cmd_t code, input logic [15:0] data, output logic got,
                       output logic [15:0] rdata);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_data = data;
    @(negedge clk);
    cmd_valid = 1'b0;
    // Released data is scrambled so that a stale value is never read by luck.
    cmd_data = ~data;
    got = rsp_valid;
    rdata = rsp_data;
  endtask : issue
endmodule : isr_host_model

`default_nettype wire

/* File: tb/testbench.sv */
/*
  Self-checking testbench of the status reporting block.
  Assumes the host model drives the command port; levels and event pulses
  are driven here at the falling edge.
*/
`default_nettype none

module testbench
  import isr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic msg;
    logic err;
    logic rdy;
    logic [7:0] service_request_enable;
    logic [7:0] stb;
    logic srq;
  } isr_row_t;

  logic clk;
  logic rst_n;
  logic cmd_valid;
  isr_cmd_t cmd_code;
  logic [15:0] cmd_data;
  logic msg_available;
  logic err_queue_pending;
  logic ready_summary;
  logic [5:0] evt;
  logic [15:0] operational_summary_bit_evt;
  logic [15:0] ques_evt;
  logic srq;
  logic rsp_valid;
  logic [15:0] rsp_data;
  int fail_count = 0;
  int n_checks = 0;
  int bits[6] = '{ESR_URQ_BIT, ESR_CMD_BIT, ESR_EXE_BIT, ESR_DDE_BIT, ESR_QYE_BIT, ESR_OPC_BIT};
  isr_cmd_t en_wr[2] = '{ISR_CMD_OPERATIONAL_SUMMARY_BIT_EN_WRITE, ISR_CMD_QUES_EN_WRITE};
  isr_cmd_t en_rd[2] = '{ISR_CMD_OPERATIONAL_SUMMARY_BIT_EN_QUERY, ISR_CMD_QUES_EN_QUERY};
  isr_cmd_t ev_rd[2] = '{ISR_CMD_OPERATIONAL_SUMMARY_BIT_QUERY, ISR_CMD_QUES_QUERY};
  isr_row_t rows[6] = '{
    '{1'b1, 1'b0, 1'b0, 8'h14, 8'h50, 1'b1},
    '{1'b0, 1'b1, 1'b0, 8'h14, 8'h44, 1'b1},
    '{1'b0, 1'b0, 1'b1, 8'h14, 8'h01, 1'b0},
    '{1'b0, 1'b0, 1'b1, 8'h01, 8'h41, 1'b1},
    '{1'b1, 1'b0, 1'b0, 8'h40, 8'h10, 1'b0},
    '{1'b0, 1'b0, 1'b0, 8'hff, 8'h00, 1'b0}
  };

  isr_status_reporting dut (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .msg_available(msg_available),
    .err_queue_pending(err_queue_pending), .ready_summary(ready_summary),
    .manual_local_evt(evt[0]), .command_error_evt(evt[1]), .execution_error_evt(evt[2]),
    .internal_fault_evt(evt[3]), .protocol_error_evt(evt[4]),
    .operations_done_evt(evt[5]), .operational_summary_bit_evt(operational_summary_bit_evt), .ques_evt(ques_evt),
    .srq(srq), .rsp_valid(rsp_valid), .rsp_data(rsp_data)
  );

  isr_host_model host (
    .clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic query(input isr_cmd_t code, input logic [15:0] exp, input string what);
    logic got;
    logic [15:0] d;
    host.issue(code, 16'h0000, got, d);
    check({what, " reply strobe"}, 16'h0001, {15'h0000, got});
    check(what, exp, d);
  endtask : query

  task automatic write_cmd(input isr_cmd_t code, input logic [15:0] data);
    logic got;
    logic [15:0] d;
    host.issue(code, data, got, d);
    check("write reply strobe", 16'h0000, {15'h0000, got});
  endtask : write_cmd

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc

  task automatic check_srq(input logic exp);
    check("srq", {15'h0000, exp}, {15'h0000, srq});
  endtask : check_srq

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    msg_available = 1'b0;
    err_queue_pending = 1'b0;
    ready_summary = 1'b0;
    evt = 6'h00;
    operational_summary_bit_evt = 16'h0000;
    ques_evt = 16'h0000;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      msg_available = rows[i].msg;
      err_queue_pending = rows[i].err;
      ready_summary = rows[i].rdy;
      write_cmd(ISR_CMD_SRE_WRITE, {8'h00, rows[i].service_request_enable});
      wait_cyc(2);
      check_srq(rows[i].srq);
      query(ISR_CMD_STB_QUERY, {8'h00, rows[i].stb}, "status byte");
    end
    rst_n = 1'b0;
    msg_available = 1'b0;
    err_queue_pending = 1'b0;
    ready_summary = 1'b0;
    wait_cyc(2);
    rst_n = 1'b1;
    query(ISR_CMD_ESR_QUERY, 16'h0080, "event reg after reset");
    query(ISR_CMD_ESR_QUERY, 16'h0000, "event reg after read");
    query(ISR_CMD_SRE_QUERY, 16'h0000, "request enable reset");
    query(ISR_CMD_ESE_QUERY, 16'h0000, "event enable reset");
    write_cmd(ISR_CMD_SRE_WRITE, 16'h0020);
    for (int i = 0; i < 6; i++) begin
      write_cmd(ISR_CMD_ESE_WRITE, 16'h0001 << bits[i]);
      @(negedge clk);
      evt = 6'h01 << i;
      @(negedge clk);
      evt = 6'h00;
      wait_cyc(1);
      check_srq(1'b1);
      query(ISR_CMD_STB_QUERY, 16'h0060, "status with event summary");
      query(ISR_CMD_ESR_QUERY, 16'h0001 << bits[i], "event bit");
      wait_cyc(2);
      check_srq(1'b0);
      query(ISR_CMD_STB_QUERY, 16'h0000, "status after event read");
    end
    // An event outside the enable mask must stay out of the summary.
    write_cmd(ISR_CMD_ESE_WRITE, 16'h0001);
    @(negedge clk);
    evt = 6'h01;
    @(negedge clk);
    evt = 6'h00;
    wait_cyc(1);
    check_srq(1'b0);
    query(ISR_CMD_STB_QUERY, 16'h0000, "masked event summary");
    write_cmd(ISR_CMD_CLEAR, 16'h0000);
    query(ISR_CMD_ESR_QUERY, 16'h0000, "event reg after clear");
    write_cmd(ISR_CMD_SRE_WRITE, 16'h0010);
    msg_available = 1'b1;
    wait_cyc(2);
    query(ISR_CMD_SERIAL_POLL, 16'h0050, "first serial poll");
    query(ISR_CMD_SERIAL_POLL, 16'h0010, "second serial poll");
    query(ISR_CMD_STB_QUERY, 16'h0050, "status query after poll");
    msg_available = 1'b0;
    for (int k = 0; k < 2; k++) begin
      write_cmd(en_wr[k], 16'hffff);
      query(en_rd[k], 16'h7fff, "lower enable");
      @(negedge clk);
      if (k == 0) begin
        operational_summary_bit_evt = 16'hffff;
      end else begin
        ques_evt = 16'hffff;
      end
      @(negedge clk);
      operational_summary_bit_evt = 16'h0000;
      ques_evt = 16'h0000;
      wait_cyc(1);
      query(ISR_CMD_STB_QUERY, 16'h0000, "status with lower events");
      query(ev_rd[k], 16'h7fff, "lower events");
      query(ev_rd[k], 16'h0000, "lower events after read");
    end
    write_cmd(isr_cmd_t'(4'he), 16'h0000);
    write_cmd(isr_cmd_t'(4'hf), 16'h0000);
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
